// ===== sct_top.sv
// clock source selection, prescaler, timers, input sync and register file
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - internal 8 MHz oscillator feeds logic clock and timer clocks, except in slave mode where the clock pin does
// - selected 8 MHz source divided by 32 gives 250 kHz clock
// - standalone: switch0 closed, switch1 open, own oscillator, clock pin floats
// - master: both switches closed, own oscillator driven onto clock pin
// - slave: switch0 open, switch1 closed, clock taken from clock pin
// - logic clock drives its output pin only when switch2 closed
// - four independent timers on divided clock, 32 us to 1.96 s
// - macrocell flip-flops all clocked by the divided logic clock
// - macrocell async reset/preset from product term, global reset or POR
// - digital inputs registered on the master clock before use
// - comparator outputs registered on the divided logic clock
// - master clock samples comparators and clocks their filters
// - filter delay 64 us when enabled, 16 us when disabled
module sct_top #(
    parameter int NUM_VMON = 10,
    parameter int NUM_DIN  = 4,
    parameter int NUM_MC   = 24
) (
    input  wire logic                                    pclk,
    input  wire logic                                    presetn,
    input  wire logic                                    psel,
    input  wire logic                                    penable,
    input  wire logic                                    pwrite,
    input  wire logic [7:0]                              paddr,
    input  wire logic [31:0]                             pwdata,
    output logic [31:0]                                  prdata,
    output logic                                         pready,
    output logic                                         pslverr,
    input  wire logic                                    internal_osc_switch,
    input  wire logic                                    clock_pin_link_switch,
    input  wire logic                                    logic_clock_out_switch,
    input  wire logic                                    mclk_pin_in,
    output logic                                         mclk_pin_out,
    output logic                                         mclk_pin_oe_n,
    output logic                                         logic_clock_out_pin,
    output logic                                         logic_clock_out_oe_n,
    output logic                                         logic_clk_en,
    input  wire logic [NUM_DIN-1:0]                      din_pin,
    output logic [NUM_DIN-1:0]                           din_q,
    input  wire logic [NUM_VMON-1:0]                     vmon_cmp,
    output logic [NUM_VMON-1:0]                          vmon_q,
    output logic [sct_pkg::NUM_TIMERS-1:0]               timer_running,
    output logic [sct_pkg::NUM_TIMERS-1:0]               timer_done,
    input  wire logic                                    global_reset_n,
    input  wire logic [NUM_MC-1:0]                       pterm_reset,
    input  wire logic [NUM_MC-1:0]                       pterm_preset,
    output logic [NUM_MC-1:0]                            mc_async_reset,
    output logic [NUM_MC-1:0]                            mc_async_preset
);
    import sct_pkg::*;

    sct_tick_if ticks ();

    // =====================================================
    // switch capture after reset release
    logic [2:0]  sw_s1;
    logic [2:0]  sw_s2;
    logic [1:0]  cfg_cnt;
    logic        cfg_done;
    sct_mode_e   mode;
    logic        lco_en;
    logic [1:0]  next_cfg_cnt;
    logic        next_cfg_done;
    sct_mode_e   next_mode;
    logic        next_lco_en;

    // settle the synchronisers, then freeze; por follows cfg_done
    always_comb begin
        next_cfg_cnt  = cfg_cnt;
        next_cfg_done = cfg_done;
        next_mode     = mode;
        next_lco_en   = lco_en;
        if (!cfg_done) begin
            next_cfg_cnt = cfg_cnt + 2'd1;
            if (cfg_cnt == 2'(CFG_SETTLE)) begin
                next_cfg_done = 1'b1;
                next_lco_en   = sw_s2[2];
                case (sw_s2[1:0])
                    2'b01:   next_mode = SCT_STANDALONE;
                    2'b11:   next_mode = SCT_MASTER;
                    2'b10:   next_mode = SCT_SLAVE;
                    default: next_mode = SCT_STANDALONE;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_s1    <= 3'b000;
            sw_s2    <= 3'b000;
            cfg_cnt  <= 2'd0;
            cfg_done <= 1'b0;
            mode     <= SCT_STANDALONE;
            lco_en   <= 1'b0;
        end else begin
            sw_s1    <= {logic_clock_out_switch, clock_pin_link_switch, internal_osc_switch};
            sw_s2    <= sw_s1;
            cfg_cnt  <= next_cfg_cnt;
            cfg_done <= next_cfg_done;
            mode     <= next_mode;
            lco_en   <= next_lco_en;
        end
    end

    // =====================================================
    // oscillator, clock pin and prescaler
    logic [6:0] osc_acc;
    logic       osc_phase;
    logic       ext_s1;
    logic       ext_s2;
    logic       ext_s3;
    logic [4:0] pre;
    logic [6:0] next_osc_acc;
    logic       next_osc_phase;
    logic [4:0] next_pre;
    logic       osc_rise;
    logic       mclk_tick;

    // fractional accumulator: 8 MHz average from 100 MHz, jitter of one pclk
    always_comb begin
        next_osc_acc   = osc_acc + 7'(OSC_STEP);
        next_osc_phase = osc_phase;
        osc_rise       = 1'b0;
        if (next_osc_acc >= 7'(PCLK_MHZ)) begin
            next_osc_acc   = next_osc_acc - 7'(PCLK_MHZ);
            next_osc_phase = ~osc_phase;
            osc_rise       = ~osc_phase;
        end
        // slave follows the pin edges; others use the own oscillator
        if (mode == SCT_SLAVE) begin
            mclk_tick = ext_s2 & ~ext_s3;
        end else begin
            mclk_tick = osc_rise;
        end
        next_pre = mclk_tick ? pre + 5'd1 : pre;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_acc   <= 7'd0;
            osc_phase <= 1'b0;
            ext_s1    <= 1'b0;
            ext_s2    <= 1'b0;
            ext_s3    <= 1'b0;
            pre       <= 5'd0;
        end else begin
            osc_acc   <= next_osc_acc;
            osc_phase <= next_osc_phase;
            ext_s1    <= mclk_pin_in;
            ext_s2    <= ext_s1;
            ext_s3    <= ext_s2;
            pre       <= next_pre;
        end
    end

    assign ticks.mclk_tick    = mclk_tick;
    assign ticks.logic_tick   = mclk_tick && (pre == 5'(PRESCALE - 1));
    assign logic_clk_en       = ticks.logic_tick;
    assign mclk_pin_out       = osc_phase;
    assign mclk_pin_oe_n      = (mode != SCT_MASTER);
    assign logic_clock_out_pin  = pre[4];
    assign logic_clock_out_oe_n = ~lco_en;

    // =====================================================
    // digital inputs: two-stage sync, then master clock register
    logic [NUM_DIN-1:0] din_s1;
    logic [NUM_DIN-1:0] din_s2;
    logic [NUM_DIN-1:0] next_din_q;

    always_comb begin
        next_din_q = mclk_tick ? din_s2 : din_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_s1 <= '0;
            din_s2 <= '0;
            din_q  <= '0;
        end else begin
            din_s1 <= din_pin;
            din_s2 <= din_s1;
            din_q  <= next_din_q;
        end
    end

    // =====================================================
    // register file state
    logic [31:0]             tcode;
    logic [NUM_VMON-1:0]     filt_en;
    logic [3:0]              mcsrc;
    logic [NUM_TIMERS-1:0]   done_flag;
    logic [31:0]             next_tcode;
    logic [NUM_VMON-1:0]     next_filt_en;
    logic [3:0]              next_mcsrc;
    logic [NUM_TIMERS-1:0]   next_done_flag;
    logic [NUM_TIMERS-1:0]   tmr_start;
    logic [NUM_TIMERS-1:0]   tmr_abort;
    logic [31:0]             next_prdata;
    logic                    wr_acc;
    logic                    hit;

    // =====================================================
    // timers and comparator paths
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
            sct_timer u_tmr (
                .pclk    (pclk),
                .presetn (presetn),
                .ticks   (ticks),
                .start   (tmr_start[gi]),
                .abort   (tmr_abort[gi]),
                .code    (tcode[gi*TCODE_STRIDE +: TMR_CODE_W]),
                .running (timer_running[gi]),
                .done    (timer_done[gi])
            );
        end
        for (gi = 0; gi < NUM_VMON; gi++) begin : g_vmon
            sct_vmon_filter u_filt (
                .pclk    (pclk),
                .presetn (presetn),
                .ticks   (ticks),
                .filt_en (filt_en[gi]),
                .cmp_raw (vmon_cmp[gi]),
                .cmp_out (vmon_q[gi])
            );
        end
    endgenerate

    // =====================================================
    // macrocell asynchronous reset and preset sources
    logic              grst_s1;
    logic              grst_s2;
    logic [NUM_MC-1:0] next_mc_rst;
    logic [NUM_MC-1:0] next_mc_pre;

    function automatic logic [NUM_MC-1:0] pick(input logic [1:0] sel,
                                               input logic [NUM_MC-1:0] pt,
                                               input logic grst, input logic por);
        case (sct_asrc_e'(sel))
            SCT_SRC_NONE:   pick = '0;
            SCT_SRC_PTERM:  pick = pt;
            SCT_SRC_GLOBAL: pick = {NUM_MC{grst}};
            SCT_SRC_POR:    pick = {NUM_MC{por}};
            default:        pick = '0;
        endcase
    endfunction

    always_comb begin
        next_mc_rst = pick(mcsrc[MCSRC_RST_LSB +: 2], pterm_reset, ~grst_s2, ~cfg_done);
        next_mc_pre = pick(mcsrc[MCSRC_PRE_LSB +: 2], pterm_preset, ~grst_s2, ~cfg_done);
    end

    // cells held in reset while power-on is in progress
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grst_s1         <= 1'b1;
            grst_s2         <= 1'b1;
            mc_async_reset  <= '1;
            mc_async_preset <= '0;
        end else begin
            grst_s1         <= global_reset_n;
            grst_s2         <= grst_s1;
            mc_async_reset  <= next_mc_rst;
            mc_async_preset <= next_mc_pre;
        end
    end

    // =====================================================
    // apb slave: zero wait, read data staged in the setup cycle
    assign pready = 1'b1;
    assign wr_acc = psel && penable && pwrite;
    assign hit    = (paddr == ADDR_CTRL) || (paddr == ADDR_TCODE) || (paddr == ADDR_FILT)
                 || (paddr == ADDR_MCSRC) || (paddr == ADDR_STATUS) || (paddr == ADDR_VMON);
    assign pslverr = psel && penable && !hit;

    always_comb begin
        next_tcode     = tcode;
        next_filt_en   = filt_en;
        next_mcsrc     = mcsrc;
        next_done_flag = done_flag;
        tmr_start      = '0;
        tmr_abort      = '0;
        next_prdata    = prdata;
        if (wr_acc) begin
            case (paddr)
                ADDR_CTRL: begin
                    tmr_start = pwdata[CTRL_START_LSB +: NUM_TIMERS];
                    tmr_abort = pwdata[CTRL_ABORT_LSB +: NUM_TIMERS];
                end
                ADDR_TCODE:  next_tcode   = pwdata & 32'h7f7f_7f7f;
                ADDR_FILT:   next_filt_en = pwdata[NUM_VMON-1:0];
                ADDR_MCSRC:  next_mcsrc   = pwdata[3:0];
                ADDR_STATUS: next_done_flag = done_flag & ~pwdata[STAT_DONE_LSB +: NUM_TIMERS];
                default:     next_done_flag = done_flag;
            endcase
        end
        // a timeout in the clearing cycle survives
        next_done_flag = next_done_flag | timer_done;
        if (psel && !penable && !pwrite) begin
            next_prdata = 32'h0000_0000;
            case (paddr)
                ADDR_TCODE:  next_prdata = tcode;
                ADDR_FILT:   next_prdata[NUM_VMON-1:0] = filt_en;
                ADDR_MCSRC:  next_prdata[3:0] = mcsrc;
                ADDR_STATUS: begin
                    next_prdata[STAT_MODE_LSB +: 2]          = mode;
                    next_prdata[STAT_LCO_BIT]                = lco_en;
                    next_prdata[STAT_CFG_BIT]                = cfg_done;
                    next_prdata[STAT_RUN_LSB +: NUM_TIMERS]  = timer_running;
                    next_prdata[STAT_DONE_LSB +: NUM_TIMERS] = done_flag;
                    next_prdata[STAT_DIN_LSB +: NUM_DIN]     = din_q;
                end
                ADDR_VMON:   next_prdata[NUM_VMON-1:0] = vmon_q;
                default:     next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcode     <= TCODE_RST;
            filt_en   <= NUM_VMON'(FILT_RST);
            mcsrc     <= MCSRC_RST;
            done_flag <= '0;
            prdata    <= 32'h0000_0000;
        end else begin
            tcode     <= next_tcode;
            filt_en   <= next_filt_en;
            mcsrc     <= next_mcsrc;
            done_flag <= next_done_flag;
            prdata    <= next_prdata;
        end
    end
endmodule

// ===== sct_pkg.sv
// shared constants and types of the supervisor clock and timer block
package sct_pkg;
    // =====================================================
    // clock rates and derived counts
    localparam int PCLK_MHZ        = 100;
    localparam int OSC_MHZ         = 8;
    localparam int PRESCALE        = 32;
    localparam int OSC_STEP        = 2 * OSC_MHZ;
    localparam int FILT_OFF_US     = 16;
    localparam int FILT_ON_US      = 64;
    localparam int FILT_OFF_TICKS  = FILT_OFF_US * OSC_MHZ;
    localparam int FILT_ON_TICKS   = FILT_ON_US * OSC_MHZ;
    localparam int FILT_CNT_W      = 10;
    localparam int CFG_SETTLE      = 3;
    // =====================================================
    // timers
    localparam int NUM_TIMERS      = 4;
    localparam int TMR_CODE_W      = 7;
    localparam int TMR_CNT_W       = 19;
    localparam int TMR_MANT_W      = 3;
    // =====================================================
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_TCODE  = 8'h04;
    localparam logic [7:0] ADDR_FILT   = 8'h08;
    localparam logic [7:0] ADDR_MCSRC  = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_VMON   = 8'h14;
    // field positions
    localparam int CTRL_START_LSB  = 0;
    localparam int CTRL_ABORT_LSB  = 4;
    localparam int TCODE_STRIDE    = 8;
    localparam int MCSRC_RST_LSB   = 0;
    localparam int MCSRC_PRE_LSB   = 2;
    localparam int STAT_MODE_LSB   = 0;
    localparam int STAT_LCO_BIT    = 2;
    localparam int STAT_CFG_BIT    = 3;
    localparam int STAT_RUN_LSB    = 4;
    localparam int STAT_DONE_LSB   = 8;
    localparam int STAT_DIN_LSB    = 12;
    // reset values
    localparam logic [31:0] TCODE_RST = 32'h0000_0000;
    localparam logic [31:0] FILT_RST  = 32'h0000_0000;
    localparam logic [3:0]  MCSRC_RST = 4'hf;
    // =====================================================
    // clock modes and asynchronous reset/preset sources
    typedef enum logic [1:0] {
        SCT_STANDALONE = 2'b00,
        SCT_MASTER     = 2'b01,
        SCT_SLAVE      = 2'b10
    } sct_mode_e;
    typedef enum logic [1:0] {
        SCT_SRC_NONE   = 2'b00,
        SCT_SRC_PTERM  = 2'b01,
        SCT_SRC_GLOBAL = 2'b10,
        SCT_SRC_POR    = 2'b11
    } sct_asrc_e;
endpackage

// ===== sct_tick_if.sv
// tick strobes shared between the clock core and its timers and filters
`timescale 1ns/1ps
interface sct_tick_if;
    logic mclk_tick;   // one pclk cycle per master clock period
    logic logic_tick;  // one pclk cycle per divided clock period
    modport src (output mclk_tick, output logic_tick);
    modport snk (input mclk_tick, input logic_tick);
endinterface

// ===== sct_timer.sv
// one programmable interval timer on the divided clock
`timescale 1ns/1ps
module sct_timer #(
    parameter int CODE_W = sct_pkg::TMR_CODE_W,
    parameter int CNT_W  = sct_pkg::TMR_CNT_W
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    sct_tick_if.snk                ticks,
    input  wire logic              start,
    input  wire logic              abort,
    input  wire logic [CODE_W-1:0] code,
    output logic                   running,
    output logic                   done
);
    import sct_pkg::*;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             next_running;
    logic             next_done;
    logic [CNT_W-1:0] load;

    // =====================================================
    // code to ticks: (8 + low bits) shifted by high bits
    always_comb begin
        load = CNT_W'({1'b1, code[TMR_MANT_W-1:0]}) << code[CODE_W-1:TMR_MANT_W];
    end

    // abort beats start; restart while running reloads
    always_comb begin
        next_cnt     = cnt;
        next_running = running;
        next_done    = 1'b0;
        if (abort) begin
            next_running = 1'b0;
            next_cnt     = '0;
        end else if (start) begin
            next_running = 1'b1;
            next_cnt     = load;
        end else if (running && ticks.logic_tick) begin
            next_cnt = cnt - CNT_W'(1);
            if (cnt == CNT_W'(1)) begin
                next_running = 1'b0;
                next_done    = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt     <= '0;
            running <= 1'b0;
            done    <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            running <= next_running;
            done    <= next_done;
        end
    end
endmodule

// ===== sct_vmon_filter.sv
// comparator sampling, digital filter and sync to the divided clock
`timescale 1ns/1ps
module sct_vmon_filter (
    input  wire logic pclk,
    input  wire logic presetn,
    sct_tick_if.snk   ticks,
    input  wire logic filt_en,
    input  wire logic cmp_raw,
    output logic      cmp_out
);
    import sct_pkg::*;
    logic                  sync1;
    logic                  sync2;
    logic                  stable;
    logic [FILT_CNT_W-1:0] cnt;
    logic                  next_stable;
    logic [FILT_CNT_W-1:0] next_cnt;
    logic                  next_out;
    logic [FILT_CNT_W-1:0] limit;

    // =====================================================
    // change accepted only after it holds for the whole window
    always_comb begin
        limit       = filt_en ? FILT_CNT_W'(FILT_ON_TICKS) : FILT_CNT_W'(FILT_OFF_TICKS);
        next_stable = stable;
        next_cnt    = cnt;
        next_out    = cmp_out;
        if (ticks.mclk_tick) begin
            if (sync2 == stable) begin
                next_cnt = '0;
            end else if (cnt == limit - FILT_CNT_W'(1)) begin
                next_stable = sync2;
                next_cnt    = '0;
            end else begin
                next_cnt = cnt + FILT_CNT_W'(1);
            end
        end
        if (ticks.logic_tick) begin
            next_out = stable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1   <= 1'b0;
            sync2   <= 1'b0;
            stable  <= 1'b0;
            cnt     <= '0;
            cmp_out <= 1'b0;
        end else begin
            sync1   <= cmp_raw;
            sync2   <= sync1;
            stable  <= next_stable;
            cnt     <= next_cnt;
            cmp_out <= next_out;
        end
    end
endmodule

// ===== sct_chk.sv
// assertions on the ports of the clock and timer block
`timescale 1ns/1ps
module sct_chk #(
    parameter int NUM_VMON = 10
) (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                internal_osc_switch,
    input wire logic                clock_pin_link_switch,
    input wire logic                logic_clock_out_switch,
    input wire logic                mclk_pin_out,
    input wire logic                mclk_pin_oe_n,
    input wire logic                logic_clock_out_pin,
    input wire logic                logic_clock_out_oe_n,
    input wire logic                logic_clk_en,
    input wire logic [NUM_VMON-1:0] vmon_q,
    input wire logic [3:0]          timer_running,
    input wire logic [3:0]          timer_done
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ======================================
    // cycles since the last divided pulse; held at zero until the first, so start-up is not judged
    logic [9:0] gap;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) gap <= 10'h000;
        else gap <= logic_clk_en ? 10'h001 : gap + {9'h000, gap != 10'h000};
    // a driven clock pin moves within one half period (6-7 cycles, 200 for the logic clock)
    sequence s_mclk_moves;
        ##[1:8] !$stable(mclk_pin_out);
    endsequence
    sequence s_lco_moves;
        ##[1:202] !$stable(logic_clock_out_pin);
    endsequence
    mclk_mode_a: assert property (!mclk_pin_oe_n |-> internal_osc_switch && clock_pin_link_switch)
        else $error("clock pin driven outside master mode");
    mclk_moves_a: assert property (!mclk_pin_oe_n |-> s_mclk_moves)
        else $error("clock pin stuck");
    lco_switch_a: assert property (!logic_clock_out_oe_n |-> logic_clock_out_switch)
        else $error("logic clock pin driven with switch open");
    lco_moves_a: assert property (!logic_clock_out_oe_n |-> s_lco_moves)
        else $error("logic clock pin stuck");
    tick_spacing_a: assert property (logic_clk_en && gap != 10'h000 |-> gap inside {[10'h18f:10'h191]})
        else $error("divided pulse spacing off");
    tick_single_a: assert property (logic_clk_en |=> !logic_clk_en [*8])
        else $error("divided pulse too long");
    vmon_on_tick_a: assert property (!$stable(vmon_q) |-> $past(logic_clk_en))
        else $error("comparator output moved off a divided tick");
    timer_end_a: assert property (|timer_done |-> (timer_done & (timer_running | ~$past(timer_running))) == 4'h0)
        else $error("timer done without running falling");
endmodule
bind sct_top sct_chk #(.NUM_VMON(NUM_VMON)) u_chk (.pclk, .presetn, .internal_osc_switch, .clock_pin_link_switch,
    .logic_clock_out_switch, .mclk_pin_out, .mclk_pin_oe_n, .logic_clock_out_pin, .logic_clock_out_oe_n,
    .logic_clk_en, .vmon_q, .timer_running, .timer_done);

// ===== sct_peer.sv
// far-end supervisor that sources the shared master clock line
`timescale 1ns/1ps
module sct_peer (
    input  wire logic drive_en,
    output logic      clk_line
);
    // 8 MHz while it is master; a floating line gets a fast pattern, never a steady level
    initial clk_line = 1'b0;
    always #(drive_en ? 62.5 : 3.0) clk_line = ~clk_line;
endmodule

// ===== sct_top_test.sv
// self-checking bench for the clock and timer block
`timescale 1ns/1ps
module sct_top_test;
    import sct_pkg::*;
    // ======================================
    // stimulus and outputs, named as the ports
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, global_reset_n = 1'b1;
    logic        internal_osc_switch = 1'b1, clock_pin_link_switch = 1'b0, logic_clock_out_switch = 1'b0;
    logic        pready, pslverr, err, mclk_pin_out, mclk_pin_oe_n, peer_clk, logic_clock_out_pin;
    logic        logic_clock_out_oe_n, logic_clk_en;
    logic [7:0]  paddr = 8'h00;
    logic [3:0]  din_pin = 4'h0, din_q, timer_running, timer_done;
    logic [9:0]  vmon_cmp = 10'h000, vmon_q;
    logic [23:0] pterm_reset = 24'h00_0000, pterm_preset = 24'h00_0000, mc_async_reset, mc_async_preset;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    int          fails = 0, total_checks = 0, cyc = 0;
    // the line carries the device while it drives, else peer
    wire         mclk_pin_in = !mclk_pin_oe_n ? mclk_pin_out : peer_clk;
    sct_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .internal_osc_switch, .clock_pin_link_switch, .logic_clock_out_switch, .mclk_pin_in, .mclk_pin_out,
        .mclk_pin_oe_n, .logic_clock_out_pin, .logic_clock_out_oe_n, .logic_clk_en, .din_pin, .din_q, .vmon_cmp,
        .vmon_q, .timer_running, .timer_done, .global_reset_n, .pterm_reset, .pterm_preset, .mc_async_reset,
        .mc_async_preset);
    sct_peer peer (.drive_en(!internal_osc_switch && clock_pin_link_switch), .clk_line(peer_clk));
    // clock, and a guard well past the ~12k cycles the tests need
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            conclude();
        end
    end
    // ======================================
    task automatic chk(input logic [31:0] v, input logic [31:0] e);
        total_checks++;
        if (v !== e) fails++;
        if (v !== e) $display("wrong value at %0t: got %h expected %h", $time, v, e);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // switches only count when sampled at reset, so each mode needs its own reset
    task automatic do_reset(input logic [2:0] sw);
        @(posedge pclk);
        {presetn, logic_clock_out_switch, clock_pin_link_switch, internal_osc_switch} <= {1'b0, sw};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic t_modes();
        logic [2:0] sw [3] = '{3'b101, 3'b011, 3'b110};
        int n;
        for (int i = 0; i < 3; i++) begin
            do_reset(sw[i]);
            apb(1'b0, ADDR_STATUS, 32'h0000_0000);
            chk(rd[3:0], {1'b1, sw[i][2], i[1:0]});
            chk(mclk_pin_oe_n, i != 1);
            chk(logic_clock_out_oe_n, !sw[i][2]);
            n = 0;
            while (logic_clk_en !== 1'b1) @(posedge pclk);
            do begin
                @(posedge pclk);
                n++;
            end while (logic_clk_en !== 1'b1);
            chk(n >= 400 - i / 2 && n <= 400 + i / 2, 1'b1);
        end
        $display("clock modes test done");
    endtask
    task automatic t_timer();
        int n = 0;
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk({rd[30:0], err}, 32'h0000_0001);
        apb(1'b1, ADDR_TCODE, 32'h80ff_0100);
        apb(1'b0, ADDR_TCODE, 32'h0000_0000);
        chk(rd, 32'h007f_0100);
        apb(1'b1, ADDR_CTRL, 32'h0000_0047);
        do begin
            @(posedge pclk);
            n += int'(logic_clk_en);
        end while (timer_done[0] !== 1'b1);
        chk(n, 8);
        chk(timer_running[2:1], 2'b01);
        apb(1'b1, ADDR_CTRL, 32'h0000_0020);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk(rd[11:4], 8'h10);
        $display("timer test done");
    endtask
    task automatic t_filter();
        int n = 0;
        int m = 0;
        apb(1'b0, ADDR_MCSRC, 32'h0000_0000);
        chk(rd, 32'h0000_000f);
        apb(1'b1, ADDR_MCSRC, 32'h0000_0009);
        apb(1'b1, ADDR_FILT, 32'h0000_0002);
        {vmon_cmp, din_pin, pterm_reset, global_reset_n} <= {10'h003, 4'h5, 24'h00_0008, 1'b0};
        while (vmon_q[1] !== 1'b1) begin
            @(posedge pclk);
            n++;
            if (vmon_q[0] === 1'b1 && m == 0) m = n;
        end
        chk(m >= 1600 && m <= 2010, 1'b1);
        chk(n >= 6400 && n <= 6810, 1'b1);
        chk({din_q, mc_async_reset[3:0], mc_async_preset[23:20]}, 12'h58f);
        apb(1'b0, ADDR_VMON, 32'h0000_0000);
        chk(rd, 32'h0000_0003);
        $display("filter and io test done");
    endtask
    initial begin
        t_modes();
        t_timer();
        t_filter();
        conclude();
    end
endmodule
